// ===== design/tgp_pkg.sv
// constants for the timer-shared eight-pin port
package tgp_pkg;
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned PORT_W          = 8;
  localparam int unsigned FRT_N           = 3;
  // byte addresses
  localparam logic [15:0] ADDR_DIRECTION  = 16'hFF8C;
  localparam logic [15:0] ADDR_DATA       = 16'hFF8E;
  localparam logic [15:0] ADDR_FUNCTION   = 16'hFF80;
  localparam logic [15:0] ADDR_STANDBY    = 16'hFF84;
  // reset values, plus the fixed direction read value
  localparam logic [7:0]  DIRECTION_RST   = 8'h00;
  localparam logic [7:0]  DATA_RST        = 8'h00;
  localparam logic [11:0] FUNCTION_RST    = 12'h000;
  localparam logic [1:0]  STANDBY_RST     = 2'h0;
  localparam logic [7:0]  DIRECTION_READ  = 8'hFF;
  // function register layout
  localparam int unsigned FN_W            = 12;
  localparam int unsigned FN_OEA1         = 0;
  localparam int unsigned FN_OEB_LO       = 1;
  localparam int unsigned FN_CKS_LO       = 4;
  localparam int unsigned FN_CCLR_LO      = 10;
  localparam logic [1:0]  CKS_EXTERNAL    = 2'h3;
  localparam logic [1:0]  CCLR_EXTERNAL   = 2'h3;
  // standby register layout
  localparam int unsigned SB_W            = 2;
  localparam int unsigned SB_SOFT         = 0;
  localparam int unsigned SB_HARD         = 1;
  // pin positions
  localparam int unsigned PIN_CMP_A       = 7;
  localparam int unsigned PIN_CMP_B_LO    = 4;
  localparam int unsigned PIN_CAPTURE_LO  = 1;
  localparam int unsigned PIN_BYTE_RESET  = 3;
  localparam int unsigned PIN_BYTE_CLOCK  = 0;
endpackage

// ===== design/tgp_pin_mux.sv
// per-pin function selection between plain i/o and timer signals
`timescale 1ns/100ps
module tgp_pin_mux
(
  input  wire logic [7:0]  port_pin_direction,
  input  wire logic [7:0]  port_pin_data,
  input  wire logic [7:0]  pin_in,
  input  wire logic [11:0] pin_function,
  input  wire logic        soft_standby,
  input  wire logic        freerun_compare_a_out,
  input  wire logic [2:0]  freerun_compare_b_out,
  output logic      [7:0]  next_pin_oe,
  output logic      [7:0]  next_pin_out,
  output logic      [2:0]  next_ext_clock,
  output logic      [2:0]  next_capture,
  output logic             next_byte_reset,
  output logic             next_byte_clock
);
  //////////////////////////////////////////////////////////////////////////////
  // no operating-mode input exists, so every chip mode sees the same selection [RULE2]
  // soft standby parks the supporting modules, so their pin claims fall away
  wire       tmr_live = !soft_standby;                                    // [RULE12]
  wire       oea_eff  = pin_function[tgp_pkg::FN_OEA1] && tmr_live;
  wire [2:0] oeb_eff  = pin_function[tgp_pkg::FN_OEB_LO +: tgp_pkg::FRT_N] & {3{tmr_live}};
  wire [1:0] cclr     = pin_function[tgp_pkg::FN_CCLR_LO +: 2];

  //////////////////////////////////////////////////////////////////////////////
  // timer-driven pins ignore the direction bit; all others follow it
  wire [7:0] timer_drive = {oea_eff, oeb_eff[2], oeb_eff[1], oeb_eff[0], 4'h0};
  wire [7:0] timer_level = {freerun_compare_a_out, freerun_compare_b_out[2],
                            freerun_compare_b_out[1], freerun_compare_b_out[0], 4'h0};
  assign next_pin_oe  = timer_drive | port_pin_direction;                   // [RULE3] [RULE4] [RULE9]
  assign next_pin_out = (timer_drive & timer_level) | (~timer_drive & port_pin_data); // [RULE3] [RULE4]

  //////////////////////////////////////////////////////////////////////////////
  // timer inputs
  genvar i;
  generate
    for (i = 0; i < tgp_pkg::FRT_N; i++)
    begin : g_frt
      wire [1:0] cks = pin_function[tgp_pkg::FN_CKS_LO + 2*i +: 2];
      assign next_ext_clock[i] = tmr_live && !oeb_eff[i] && (cks == tgp_pkg::CKS_EXTERNAL)
                                 && pin_in[tgp_pkg::PIN_CMP_B_LO + i];            // [RULE5]
      assign next_capture[i]   = tmr_live && pin_in[tgp_pkg::PIN_CAPTURE_LO + i]; // [RULE6]
    end
  endgenerate

  assign next_byte_reset = tmr_live && (cclr == tgp_pkg::CCLR_EXTERNAL)
                           && pin_in[tgp_pkg::PIN_BYTE_RESET];                    // [RULE7]
  // the byte timer applies its own clock select to this level
  assign next_byte_clock = tmr_live && pin_in[tgp_pkg::PIN_BYTE_CLOCK];           // [RULE8]
endmodule // tgp_pin_mux

// ===== design/tgp_port.sv
// apb-attached eight-pin port shared with free-running and byte timers
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] data read: latch if output, else pin
// [RULE2] pin selection same in every mode
// [RULE3] pin 7 drives compare a when enabled
// [RULE4] pins 6..4 drive compare b when enabled
// [RULE5] pins 6..4 feed external clock when selected
// [RULE6] pins 3..1 plain i/o plus capture
// [RULE7] pin 3 byte timer reset when clear=11
// [RULE8] pin 0 plain i/o plus byte clock
// [RULE9] direction bit 1 output, 0 input
// [RULE10] direction reads all ones, no error
// [RULE11] reset, hard standby clear direction; soft keeps
// [RULE12] soft standby returns timer pins to plain
// [RULE13] data latch writable in any direction
module tgp_port
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  input  wire logic        freerun_compare_a_out,
  input  wire logic [2:0]  freerun_compare_b_out,
  output logic      [2:0]  freerun_ext_clock_in,
  output logic      [2:0]  freerun_capture_in,
  output logic             byte_timer_reset_in,
  output logic             byte_timer_clock_in
);
  //////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]  port_pin_direction;
  logic [7:0]  port_pin_data;
  logic [11:0] pin_function;
  logic [1:0]  standby;

  wire soft_standby = standby[tgp_pkg::SB_SOFT];
  wire hard_standby = standby[tgp_pkg::SB_HARD];

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup_phase = psel && !penable;
  wire access_done = psel && penable && pready;
  wire wr_done     = access_done && pwrite;

  // full sixteen-bit compare: a partial decode would alias the
  // neighbouring ports' registers onto this block
  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
    return addr == target;
  endfunction

  wire hit_direction = addr_hit(paddr, tgp_pkg::ADDR_DIRECTION);
  wire hit_data      = addr_hit(paddr, tgp_pkg::ADDR_DATA);
  wire hit_function  = addr_hit(paddr, tgp_pkg::ADDR_FUNCTION);
  wire hit_standby   = addr_hit(paddr, tgp_pkg::ADDR_STANDBY);
  wire hit_any       = hit_direction || hit_data || hit_function || hit_standby;

  wire wr_direction = wr_done && hit_direction && pstrb[0];
  wire wr_data      = wr_done && hit_data && pstrb[0];
  wire wr_fn_lo     = wr_done && hit_function && pstrb[0];
  wire wr_fn_hi     = wr_done && hit_function && pstrb[1];
  wire wr_standby   = wr_done && hit_standby && pstrb[0];

  //////////////////////////////////////////////////////////////////////////////
  // next values
  logic [7:0] next_pin_oe;
  logic [7:0] next_pin_out;
  logic [2:0] next_ext_clock;
  logic [2:0] next_capture;
  logic       next_byte_reset;
  logic       next_byte_clock;

  // hard standby holds direction and data at their reset values; soft standby leaves them alone
  wire [7:0] next_direction = hard_standby ? tgp_pkg::DIRECTION_RST :
                              wr_direction ? pwdata[7:0] : port_pin_direction;   // [RULE11]
  // latch takes writes whatever the direction, so a value can be staged
  wire [7:0] next_data      = hard_standby ? tgp_pkg::DATA_RST :
                              wr_data      ? pwdata[7:0] : port_pin_data;        // [RULE13]
  wire [11:0] next_function = {wr_fn_hi ? pwdata[11:8] : pin_function[11:8],
                               wr_fn_lo ? pwdata[7:0]  : pin_function[7:0]};
  wire [1:0] next_standby   = wr_standby ? pwdata[1:0] : standby;

  // driven bits read back the latch, undriven bits the live pin
  wire [7:0] data_view = (pin_oe & port_pin_data) | (~pin_oe & pin_in);          // [RULE1]

  wire [31:0] read_mux = hit_data      ? {24'h000000, data_view} :
                         hit_direction ? {24'h000000, tgp_pkg::DIRECTION_READ} : // [RULE10]
                         hit_function  ? {20'h00000, pin_function} :
                         hit_standby   ? {30'h0, standby} :
                                         32'h00000000;

  // the answer is prepared in the setup cycle, so every access ends after one
  // access cycle; the pin level is thus sampled one cycle before the access edge
  wire        next_pready  = setup_phase;
  wire        next_pslverr = setup_phase && !hit_any;
  wire [31:0] next_prdata  = (setup_phase && !pwrite) ? read_mux : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // pin selection
  tgp_pin_mux u_mux
  (
    .port_pin_direction    (port_pin_direction),
    .port_pin_data         (port_pin_data),
    .pin_in                (pin_in),
    .pin_function          (pin_function),
    .soft_standby          (soft_standby),
    .freerun_compare_a_out (freerun_compare_a_out),
    .freerun_compare_b_out (freerun_compare_b_out),
    .next_pin_oe           (next_pin_oe),
    .next_pin_out          (next_pin_out),
    .next_ext_clock        (next_ext_clock),
    .next_capture          (next_capture),
    .next_byte_reset       (next_byte_reset),
    .next_byte_clock       (next_byte_clock)
  );

  //////////////////////////////////////////////////////////////////////////////
  // software-visible registers; one flop group per process keeps each short
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_pin_direction <= tgp_pkg::DIRECTION_RST;                             // [RULE11]
    end
    else
    begin
      port_pin_direction <= next_direction;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_pin_data <= tgp_pkg::DATA_RST;
    end
    else
    begin
      port_pin_data <= next_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_function <= tgp_pkg::FUNCTION_RST;
    end
    else
    begin
      pin_function <= next_function;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      standby <= tgp_pkg::STANDBY_RST;
    end
    else
    begin
      standby <= next_standby;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus answer; registered, so the slave never answers in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= '0;
    end
    else
    begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= '0;
    end
    else
    begin
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins and timer inputs lag their causes by one cycle
  // pins come out of reset released, so nothing fights the board
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_oe <= tgp_pkg::DIRECTION_RST;
    end
    else
    begin
      pin_oe <= next_pin_oe;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= tgp_pkg::DATA_RST;
    end
    else
    begin
      pin_out <= next_pin_out;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freerun_ext_clock_in <= '0;
    end
    else
    begin
      freerun_ext_clock_in <= next_ext_clock;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freerun_capture_in <= '0;
    end
    else
    begin
      freerun_capture_in <= next_capture;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_timer_reset_in <= '0;
    end
    else
    begin
      byte_timer_reset_in <= next_byte_reset;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_timer_clock_in <= '0;
    end
    else
    begin
      byte_timer_clock_in <= next_byte_clock;
    end
  end
endmodule // tgp_port

// ===== sim/tgp_pin_model.sv
// external circuitry seen by the eight port pins
`timescale 1ns/100ps
module tgp_pin_model
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  // a driven pin reads back its own drive, a released one the outside level
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // tgp_pin_model

// ===== sim/tgp_port_chk.sv
// concurrent checks on the port's bus answers and pin routing
`timescale 1ns/100ps
module tgp_port_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_oe,
  input wire logic [2:0]  freerun_ext_clock_in,
  input wire logic [2:0]  freerun_capture_in,
  input wire logic        byte_timer_reset_in,
  input wire logic        byte_timer_clock_in
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_acc = psel && penable && pready && !pwrite;
  wire mapped = paddr inside {tgp_pkg::ADDR_DIRECTION, tgp_pkg::ADDR_DATA,
                              tgp_pkg::ADDR_FUNCTION, tgp_pkg::ADDR_STANDBY};
  ready_timing_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  dir_read_a: assert property (rd_acc && paddr == tgp_pkg::ADDR_DIRECTION
    |-> prdata == 32'h000000FF && !pslverr) else $error("direction read wrong");
  data_read_a: assert property (rd_acc && paddr == tgp_pkg::ADDR_DATA
    |-> ((prdata[7:0] ^ $past(pin_in)) & ~$past(pin_oe)) == 8'h00)
    else $error("input pin read wrong");
  unmapped_err_a: assert property (psel && penable && pready |-> pslverr == !mapped)
    else $error("error response wrong");
  capture_route_a: assert property ((freerun_capture_in & ~$past(pin_in[3:1])) == 3'h0)
    else $error("capture not from pin");
  ext_clock_a: assert property ((freerun_ext_clock_in & ~$past(pin_in[6:4])) == 3'h0)
    else $error("external clock not from pin");
  byte_reset_a: assert property (byte_timer_reset_in |-> $past(pin_in[3]))
    else $error("byte reset not from pin");
  byte_clock_a: assert property (byte_timer_clock_in |-> $past(pin_in[0]))
    else $error("byte clock not from pin");
endmodule // tgp_port_chk
bind tgp_port tgp_port_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pin_in, .pin_oe, .freerun_ext_clock_in,
  .freerun_capture_in, .byte_timer_reset_in, .byte_timer_clock_in);

// ===== sim/tgp_port_tb.sv
// self-checking bench for the timer-shared port
`timescale 1ns/100ps
module tgp_port_tb;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err, cmp_a;
  logic        t_rst, t_clk;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pin_in, pin_out, pin_oe, ext;
  logic [2:0]  cmp_b, x_clk, cap;
  int          errors, n_tests, cyc;
  tgp_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
    .freerun_compare_a_out(cmp_a), .freerun_compare_b_out(cmp_b),
    .freerun_ext_clock_in(x_clk), .freerun_capture_in(cap),
    .byte_timer_reset_in(t_rst), .byte_timer_clock_in(t_clk));
  tgp_pin_model pins (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
  always #10 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // waits on pready itself; only the cycle ceiling ends a hang
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // pin outputs lag the register by one edge; three leave margin
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, cmp_a} = 5'h00;
    {paddr, pwdata, ext, cmp_b} = 59'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check("oe after reset", 32'h0, 32'(pin_oe));
    apb(1'b0, tgp_pkg::ADDR_DIRECTION, 32'h0);
    check("direction read", 32'h000000FF, rd);
    ext <= 8'h3C;
    wr(tgp_pkg::ADDR_DATA, 32'h000000A5);
    wr(tgp_pkg::ADDR_DIRECTION, 32'h0000000F);
    settle();
    check("oe mixed", 32'h0F, 32'(pin_oe));
    check("out low nibble", 32'h5, 32'(pin_out[3:0]));
    apb(1'b0, tgp_pkg::ADDR_DATA, 32'h0);
    check("data read", 32'h35, rd);
    apb(1'b0, 16'hFF90, 32'h0);
    check("unmapped error", 32'h1, 32'(err));
    $display("test 1 done");
    cmp_a <= 1'b1;
    cmp_b <= 3'h5;
    wr(tgp_pkg::ADDR_FUNCTION, 32'h00000FFF);
    wr(tgp_pkg::ADDR_DIRECTION, 32'h0);
    settle();
    check("oe compare", 32'hF0, 32'(pin_oe));
    check("out compare", 32'hD, 32'(pin_out[7:4]));
    check("ext clock off", 32'h0, 32'(x_clk));
    $display("test 2 done");
    ext <= 8'h7D;
    wr(tgp_pkg::ADDR_FUNCTION, 32'h00000FF0);
    settle();
    check("oe plain", 32'h0, 32'(pin_oe));
    check("ext clock", 32'h7, 32'(x_clk));
    check("capture", 32'h6, 32'(cap));
    check("byte reset", 32'h1, 32'(t_rst));
    check("byte clock", 32'h1, 32'(t_clk));
    wr(tgp_pkg::ADDR_FUNCTION, 32'h000007F0);
    settle();
    check("byte reset off", 32'h0, 32'(t_rst));
    $display("test 3 done");
    wr(tgp_pkg::ADDR_DIRECTION, 32'h000000FF);
    wr(tgp_pkg::ADDR_FUNCTION, 32'h0000000F);
    wr(tgp_pkg::ADDR_STANDBY, 32'h00000001);
    settle();
    check("oe soft", 32'hFF, 32'(pin_oe));
    check("out soft", 32'hA5, 32'(pin_out));
    // soft kept set so the still-enabled compare outputs stay parked
    wr(tgp_pkg::ADDR_STANDBY, 32'h00000003);
    settle();
    check("oe hard", 32'h0, 32'(pin_oe));
    $display("test 4 done");
    close_out();
  end
endmodule // tgp_port_tb
